/* rtl/shwc_start_hold_wake_control.sv */
/*
 * shwc_start_hold_wake_control: debounces the start request, echoes it to the
 * host wake input, runs the start-up/turn-off sequence under power hold, and
 * drives system reset.
 * assumes inputs synchronous to clk; resetn is the undervoltage lockout.
 */
`timescale 1ns/100ps
// Notes on behaviour
// - turn-on from the start input starts only after start_request_n has been low longer than the debounce time.
// - start_echo_n is pulled low whenever start_request_n is seen low or the wake pulse is high, otherwise released.
// - only the automatic wake pulse may drive start_echo_n independently of the start input.
// - once start-up runs, power hold high validates it; an already high hold also counts.
// - if power hold is low at the end of start-up or during the reset delay, a turn-off begins instead.
// - with power hold high, a new start press causes no automatic action unless timeout fires.
// - a rising edge on power hold starts power-up even without a start press.
// - power hold driven low by the host powers the channels down.
// - a start input held low by a capacitor at supply-up restarts the device and echoes a wake.
// - a supply cycle in push-button systems with the host in backup does not restart alone.
// - an aborted start-up keeps system reset low throughout with no release glitch.
// - system reset is released a set delay (default 16 ms) after successful start-up.
module shwc_start_hold_wake_control
   import shwc_pkg::*;
#(
   parameter int RESET_DELAY = RESET_DELAY_CYC
)(
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic start_request_n,
   input  wire logic power_hold,
   input  wire logic auto_wake_pulse,
   input  wire logic longpress_timeout,
   output logic      start_echo_n_o,
   output logic      start_echo_n_oe,
   output logic      system_reset_out_n_o,
   output logic      system_reset_out_n_oe,
   output logic      rails_on
);
   // -------------------------------------------------------------------------
   // debounce and hold edge
   // -------------------------------------------------------------------------
   logic [CNT_W-1:0] deb_r, deb_nxt;
   logic             start_seen_r, start_seen_nxt;
   logic             hold_d_r;
   logic             press_ev;

   // counter restarts whenever the input returns high
   always_comb begin
      deb_nxt        = deb_r;
      start_seen_nxt = start_seen_r;
      if (start_request_n) begin
         deb_nxt        = CNT_ZERO;
         start_seen_nxt = 1'b0;
      end else if (deb_r != DEBOUNCE_CYC[CNT_W-1:0]) begin
         deb_nxt = deb_r + CNT_ONE;
      end else begin
         start_seen_nxt = 1'b1;
      end
   end
   // one-cycle event when the debounced press becomes valid
   assign press_ev = start_seen_nxt && !start_seen_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         deb_r        <= CNT_ZERO;
         start_seen_r <= 1'b0;
         hold_d_r     <= 1'b1;   // no false rising edge right after lockout
      end else begin
         deb_r        <= deb_nxt;
         start_seen_r <= start_seen_nxt;
         hold_d_r     <= power_hold;
      end
   end

   // -------------------------------------------------------------------------
   // sequencer
   // -------------------------------------------------------------------------
   shwc_state_e      st_r, st_nxt;
   logic [CNT_W-1:0] tmr_r, tmr_nxt;
   logic             hold_rise;
   assign hold_rise = power_hold && !hold_d_r;

   always_comb begin
      st_nxt  = st_r;
      tmr_nxt = tmr_r + CNT_ONE;
      case (st_r)
         SHWC_OFF: begin
            tmr_nxt = CNT_ZERO;
            // a capacitor-held low after supply-up also counts as a press
            if (press_ev || hold_rise) begin
               st_nxt = SHWC_RAMP;
            end
         end
         SHWC_RAMP: begin
            if (tmr_r == SEQ_CYC[CNT_W-1:0]) begin
               tmr_nxt = CNT_ZERO;
               st_nxt  = power_hold ? SHWC_RST_WAIT : SHWC_RAMP_DOWN;
            end
         end
         SHWC_RST_WAIT: begin
            if (!power_hold) begin
               tmr_nxt = CNT_ZERO;
               st_nxt  = SHWC_RAMP_DOWN;
            end else if (tmr_r == RESET_DELAY[CNT_W-1:0]) begin
               st_nxt = SHWC_RUN;
            end
         end
         SHWC_RUN: begin
            tmr_nxt = CNT_ZERO;
            // presses are ignored here; only hold low or the long-press timeout acts
            if (!power_hold || longpress_timeout) begin
               st_nxt = SHWC_RAMP_DOWN;
            end
         end
         SHWC_RAMP_DOWN: begin
            if (tmr_r == OFF_CYC[CNT_W-1:0]) begin
               tmr_nxt = CNT_ZERO;
               st_nxt  = SHWC_OFF;
            end
         end
         default: begin
            st_nxt  = SHWC_OFF;
            tmr_nxt = CNT_ZERO;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r  <= SHWC_OFF;
         tmr_r <= CNT_ZERO;
      end else begin
         st_r  <= st_nxt;
         tmr_r <= tmr_nxt;
      end
   end

   // -------------------------------------------------------------------------
   // outputs: enables and rails registered, pin levels tied low
   // -------------------------------------------------------------------------
   logic echo_oe_r, echo_oe_nxt;
   logic rst_rel_r, rst_rel_nxt;
   logic rails_r,   rails_nxt;

   always_comb begin
      // echo follows the raw input, except during the wake pulse
      echo_oe_nxt = auto_wake_pulse ? 1'b1 : !start_request_n;
      rst_rel_nxt = (st_nxt == SHWC_RUN);
      rails_nxt   = (st_nxt == SHWC_RAMP) || (st_nxt == SHWC_RST_WAIT)
                    || (st_nxt == SHWC_RUN);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         echo_oe_r <= 1'b0;
         rst_rel_r <= 1'b0;
         rails_r   <= 1'b0;
      end else begin
         echo_oe_r <= echo_oe_nxt;
         rst_rel_r <= rst_rel_nxt;
         rails_r   <= rails_nxt;
      end
   end

   assign start_echo_n_o        = 1'b0;                      // open drain: only pulls low
   assign start_echo_n_oe       = echo_oe_r;
   assign system_reset_out_n_o  = 1'b0;
   assign system_reset_out_n_oe = !rst_rel_r;                // held low unless running
   assign rails_on              = rails_r;

   // -------------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------------
   // echo path
   a_echo_follows_in: assert property (@(posedge clk) disable iff (!resetn)
      !auto_wake_pulse |=> (start_echo_n_oe == !$past(start_request_n)))
      else $error("echo does not follow start input");
   a_wake_pulse_drives: assert property (@(posedge clk) disable iff (!resetn)
      auto_wake_pulse |=> start_echo_n_oe)
      else $error("wake pulse did not pull echo low");
   // debounce and start causes
   a_debounce_restart: assert property (@(posedge clk) disable iff (!resetn)
      start_request_n |=> deb_r == CNT_ZERO)
      else $error("debounce count not restarted by a high input");
   a_no_early_start: assert property (@(posedge clk) disable iff (!resetn)
      (st_r == SHWC_OFF && st_nxt == SHWC_RAMP)
      |-> ((!start_request_n && deb_r == DEBOUNCE_CYC[CNT_W-1:0]) || hold_rise))
      else $error("start-up without debounced press or hold rise");
   a_off_stays: assert property (@(posedge clk) disable iff (!resetn)
      (st_r == SHWC_OFF && !hold_rise
       && !(!start_request_n && deb_r == DEBOUNCE_CYC[CNT_W-1:0])) |=> st_r == SHWC_OFF)
      else $error("left off state without a start cause");
   a_hold_rise_starts: assert property (@(posedge clk) disable iff (!resetn)
      (st_r == SHWC_OFF && hold_rise) |=> st_r == SHWC_RAMP)
      else $error("hold rising edge did not start power-up");
   // end of start-up and system reset
   a_abort_no_hold: assert property (@(posedge clk) disable iff (!resetn)
      (st_r == SHWC_RAMP && tmr_r == SEQ_CYC[CNT_W-1:0] && !power_hold)
      |=> st_r == SHWC_RAMP_DOWN ##1 system_reset_out_n_oe)
      else $error("no turn-off with hold low at end of start-up");
   a_wait_hold_low: assert property (@(posedge clk) disable iff (!resetn)
      (st_r == SHWC_RST_WAIT && !power_hold)
      |=> (st_r == SHWC_RAMP_DOWN && system_reset_out_n_oe))
      else $error("hold low during reset wait did not turn off");
   a_reset_held_up: assert property (@(posedge clk) disable iff (!resetn)
      (st_r == SHWC_RAMP || st_r == SHWC_RST_WAIT) |-> system_reset_out_n_oe)
      else $error("reset released before start-up completed");
   a_reset_no_glitch: assert property (@(posedge clk) disable iff (!resetn)
      (st_r == SHWC_RAMP_DOWN) |-> system_reset_out_n_oe)
      else $error("reset released during turn-off");
   a_reset_release: assert property (@(posedge clk) disable iff (!resetn)
      $rose(st_r == SHWC_RUN) |-> !system_reset_out_n_oe)
      else $error("reset not released on run");
   // run and turn-off
   a_hold_low_off: assert property (@(posedge clk) disable iff (!resetn)
      (st_r == SHWC_RUN && !power_hold) |=> st_r == SHWC_RAMP_DOWN ##1 !rails_on)
      else $error("hold low did not power down");
   a_rails_off_idle: assert property (@(posedge clk) disable iff (!resetn)
      (st_r == SHWC_OFF || st_r == SHWC_RAMP_DOWN) |-> !rails_on)
      else $error("rails on while off or ramping down");
   a_press_ignored: assert property (@(posedge clk) disable iff (!resetn)
      (st_r == SHWC_RUN && power_hold && !longpress_timeout) |=> st_r == SHWC_RUN)
      else $error("press in run caused action");
   a_timeout_shuts: assert property (@(posedge clk) disable iff (!resetn)
      (st_r == SHWC_RUN && longpress_timeout) |=> st_r == SHWC_RAMP_DOWN)
      else $error("long-press timeout did not turn off");
endmodule

/* shared/shwc_pkg.sv */
/*
 * shwc_pkg: constants, state type and timing counts for the start, hold and
 * wake control block.
 * assumes a 125 MHz core clock; all times are turned into cycle counts here.
 */
package shwc_pkg;
   // -------------------------------------------------------------------------
   // clock and timing
   // -------------------------------------------------------------------------
   localparam int CLK_PERIOD_PS    = 8000;   // 125 MHz
   localparam int DEBOUNCE_US      = 10;     // minimum low time on the start input
   localparam int DEBOUNCE_CYC     = (DEBOUNCE_US * 1000000 + CLK_PERIOD_PS - 1)
                                     / CLK_PERIOD_PS;
   localparam int RESET_DELAY_MS   = 16;     // reset release delay after start-up
   localparam int RESET_DELAY_CYC  = RESET_DELAY_MS * (1000000000 / CLK_PERIOD_PS);
   localparam int SEQ_TIME_US      = 100;    // modelled rail start-up time
   localparam int SEQ_CYC          = (SEQ_TIME_US * 1000000 + CLK_PERIOD_PS - 1)
                                     / CLK_PERIOD_PS;
   localparam int OFF_TIME_US      = 100;    // modelled rail turn-off time
   localparam int OFF_CYC          = (OFF_TIME_US * 1000000 + CLK_PERIOD_PS - 1)
                                     / CLK_PERIOD_PS;

   localparam int CNT_W            = 24;
   localparam logic [CNT_W-1:0] CNT_ZERO = 24'h00_0000;
   localparam logic [CNT_W-1:0] CNT_ONE  = 24'h00_0001;

   // -------------------------------------------------------------------------
   // sequencer states
   // -------------------------------------------------------------------------
   typedef enum logic [2:0] {
      SHWC_OFF,
      SHWC_RAMP,
      SHWC_RST_WAIT,
      SHWC_RUN,
      SHWC_RAMP_DOWN
   } shwc_state_e;
endpackage

/* bench/shwc_host_model.sv */
/* host model: raises power hold on a wake cause, drops it on request.
   assumes echo_n is the pulled-up level of the echo wire. */
`timescale 1ns/100ps
module shwc_host_model (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       echo_n,
   input  wire logic       wake_en,
   input  wire logic       wake_req,
   input  wire logic       drop,
   input  wire logic [7:0] lat,
   output logic            power_hold,
   output logic            low_power_select
);
   logic [7:0] cnt_r;
   // hold rises lat cycles after a wake cause; select goes up before hold drops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         power_hold <= 1'b0;
         low_power_select <= 1'b0;
         cnt_r <= 8'h00;
      end else if (drop) begin
         low_power_select <= 1'b1;
         if (low_power_select) power_hold <= 1'b0;
      end else if (wake_req || (wake_en && !echo_n)) begin
         cnt_r <= cnt_r + 8'h01;
         if (cnt_r == lat) power_hold <= 1'b1;
      end else cnt_r <= 8'h00;
   end
endmodule

/* bench/tb.sv */
/* tb: drives the start, hold and wake block beside a host model.
   assumes shwc_pkg and the design are compiled first. */
`timescale 1ns/100ps
module tb;
   import shwc_pkg::*;
   logic clk = 1'b0, resetn = 1'b0, sr_n = 1'b1, aw = 1'b0, lpt = 1'b0;
   logic wake_en = 1'b0, wake_req = 1'b0, drop = 1'b0;
   logic [7:0]  lat = 8'h00;
   logic        e_o, e_oe, r_o, r_oe, rails, ph, lps;
   wire         echo_w = e_oe ? e_o : 1'b1; // echo wire with its pull-up
   logic [1:0]  q[$];
   logic [1:0]  prev = 2'b01;
   logic [31:0] lfsr = 32'h7244;
   int          n_mismatch = 0, num_checks = 0;
   initial forever #4 clk = ~clk;
   shwc_start_hold_wake_control #(.RESET_DELAY(20)) shwc_start_hold_wake_control_inst (
      .clk(clk), .resetn(resetn), .start_request_n(sr_n), .power_hold(ph),
      .auto_wake_pulse(aw), .longpress_timeout(lpt), .start_echo_n_o(e_o),
      .start_echo_n_oe(e_oe), .system_reset_out_n_o(r_o),
      .system_reset_out_n_oe(r_oe), .rails_on(rails));
   shwc_host_model shwc_host_model_inst (.clk(clk), .rstn(resetn),
      .echo_n(echo_w), .wake_en(wake_en), .wake_req(wake_req),
      .drop(drop), .lat(lat), .power_hold(ph), .low_power_select(lps));
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input logic [1:0] got, input logic [1:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // hold the start input low for n+2 cycles, watching the echo
   task automatic press(input int n);
      sr_n = 1'b0;
      tick(2);
      chk({1'b0, e_oe}, 2'b01);
      tick(n);
      sr_n = 1'b1;
      tick(2);
      chk({1'b0, e_oe}, 2'b00);
   endtask
   task automatic drain(input int n);
      int i;
      for (i = 0; i < n && q.size() != 0; i++) tick(1);
      if (q.size() != 0) begin
         n_mismatch++;
         $display("[ERR] t=%0t wait ran out got=%h exp=%h", $time, q.size(), 0);
         conclude();
      end
   endtask
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // each rails rise or reset change takes the oldest note
   always @(posedge clk) begin
      if (!resetn) begin
         prev <= 2'b01;
      end else begin
         if ((rails && !prev[1]) || r_oe !== prev[0])
            chk((r_oe !== prev[0]) ? {1'b1, r_oe} : 2'b01,
                q.size() ? q.pop_front() : 2'bxx);
         prev <= {rails, r_oe};
      end
   end
   // main sequence
   initial begin
      tick(16);
      resetn = 1'b1;
      lfsr = nxt(lfsr);
      press(lfsr[9:0]);
      press(8);
      tick(1300);
      aw = 1'b1;
      tick(2);
      chk({1'b0, e_oe}, 2'b01);
      aw = 1'b0;
      tick(2);
      chk({1'b0, e_oe}, 2'b00);
      // random wake, timeout and start levels while off: echo follows, rails stay off
      for (int k = 0; k < 8; k++) begin
         lfsr = nxt(lfsr);
         aw   = lfsr[0];
         lpt  = lfsr[1];
         sr_n = lfsr[2];
         tick(1);
         chk({rails, e_oe}, {1'b0, aw | ~sr_n});
      end
      aw   = 1'b0;
      lpt  = 1'b0;
      sr_n = 1'b1;
      tick(2);
      $display("test debounce done");
      lfsr = nxt(lfsr);
      lat = lfsr[7:0];
      wake_en = 1'b1;
      q.push_back(2'b01);
      q.push_back(2'b10);
      press(1300);
      drain(14000);
      press(1300);
      q.push_back(2'b11);
      lpt = 1'b1;
      tick(1);
      lpt = 1'b0;
      drain(20);
      tick(12600);
      chk({1'b0, rails}, 2'b00);
      wake_en = 1'b0;
      drop = 1'b1;
      tick(3);
      drop = 1'b0;
      $display("test press start done");
      q.push_back(2'b01);
      q.push_back(2'b10);
      wake_req = 1'b1;
      drain(13000);
      wake_req = 1'b0;
      q.push_back(2'b11);
      drop = 1'b1;
      tick(3);
      drop = 1'b0;
      drain(20);
      chk({1'b0, lps}, 2'b01);
      tick(12600);
      chk({1'b0, rails}, 2'b00);
      $display("test hold wake done");
      resetn = 1'b0;
      tick(2);
      resetn = 1'b1;
      tick(2000);
      chk({rails, r_oe}, 2'b01);
      resetn = 1'b0;
      sr_n = 1'b0;
      q.push_back(2'b01);
      tick(2);
      resetn = 1'b1;
      tick(2);
      chk({1'b0, e_oe}, 2'b01);
      chk({r_o, e_o}, 2'b00);
      tick(1300);
      sr_n = 1'b1;
      drain(10);
      tick(25000);
      chk({rails, r_oe}, 2'b01);
      $display("test supply cycle done");
      conclude();
   end
endmodule
